//--- design/rjb_pkg.sv
// constants, register map and state type for the register jump barrier unit
package rjb_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // datapath widths
   localparam int          XLEN          = 64;
   localparam int          INSTR_W       = 32;
   localparam int          REG_IDX_W     = 5;
   localparam int          INDEX_W       = 26;
   localparam int          ISA_CFG_W     = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction field positions and encodings
   localparam int          OP_LSB        = 26;
   localparam int          RS_LSB        = 21;
   localparam int          RT_LSB        = 16;
   localparam int          RD_LSB        = 11;
   localparam int          FN_LSB        = 0;
   localparam int          HB_BIT        = 10;
   localparam logic [5:0]  OP_SPECIAL    = 6'h00;
   localparam logic [5:0]  OP_MODE_XCHG  = 6'h1d;
   localparam logic [5:0]  FN_REG_JUMP   = 6'h09;
   localparam logic [4:0]  ZERO_REG      = 5'h00;
   localparam logic [4:0]  LINK_REG_31   = 5'h1f;

   ////////////////////////////////////////////////////////////////////////////////
   // address arithmetic
   localparam logic [XLEN-1:0] LINK_OFS  = 64'h0000_0000_0000_0008;
   localparam logic [XLEN-1:0] SLOT_OFS  = 64'h0000_0000_0000_0004;
   localparam int          REGION_LSB    = 28;
   localparam int          ALIGN_SHIFT   = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam int          AVS_ADDR_W    = 4;
   localparam logic [3:0]  REG_CTRL      = 4'h0;
   localparam logic [3:0]  REG_STATUS    = 4'h4;
   localparam logic [3:0]  REG_TGT_LO    = 4'h8;
   localparam logic [3:0]  REG_TGT_HI    = 4'hc;
   localparam int          CTRL_CA_BIT   = 0;
   localparam int          CTRL_ISA_LSB  = 1;
   localparam int          CTRL_R6_BIT   = 3;
   localparam int          CTRL_W        = 4;
   localparam logic [3:0]  CTRL_RESET    = 4'h0;
   localparam int          STAT_MODE_BIT = 0;
   localparam int          STAT_BUSY_BIT = 1;
   localparam int          STAT_BAR_BIT  = 2;

   typedef enum {RJB_IDLE, RJB_SLOT, RJB_GO} rjb_state_e;

endpackage : rjb_pkg

//--- design/rjb_dec_if.sv
// decoded jump fields passed from the decoder to the jump control
`timescale 1ns/1ps
interface rjb_dec_if;
   import rjb_pkg::*;
   logic [INSTR_W-1:0]   instr;
   logic                 is_reg_jump;
   logic                 is_xchg;
   logic                 barrier;
   logic [REG_IDX_W-1:0] src_idx;
   logic [REG_IDX_W-1:0] link_idx;
   logic [INDEX_W-1:0]   index;

   modport dec (input instr, output is_reg_jump, is_xchg, barrier, src_idx, link_idx, index);
   modport use_side (output instr, input is_reg_jump, is_xchg, barrier, src_idx, link_idx, index);
endinterface : rjb_dec_if

//--- design/rjb_decode.sv
// instruction field decoder for the register and mode exchange jumps
`timescale 1ns/1ps
module rjb_decode (
   rjb_dec_if.dec d
);
   import rjb_pkg::*;

   wire [5:0]           op_w    = d.instr[OP_LSB +: 6];
   wire [5:0]           fn_w    = d.instr[FN_LSB +: 6];
   wire [REG_IDX_W-1:0] rt_w    = d.instr[RT_LSB +: REG_IDX_W];

   // plain barrier jump is the link form with link index zero
   assign d.is_reg_jump = (op_w == OP_SPECIAL) && (fn_w == FN_REG_JUMP) && (rt_w == ZERO_REG); // RULE_13
   assign d.barrier     = d.instr[HB_BIT]; // RULE_08
   assign d.is_xchg     = (op_w == OP_MODE_XCHG); // RULE_18
   assign d.src_idx     = d.instr[RS_LSB +: REG_IDX_W];
   assign d.link_idx    = d.is_xchg ? LINK_REG_31 : d.instr[RD_LSB +: REG_IDX_W];
   assign d.index       = d.instr[0 +: INDEX_W];

endmodule : rjb_decode

//--- design/rjb_top.sv
// jump control for register jumps with hazard barrier and mode exchange jumps
// Overview of operation
// (RULE_01) register jump writes current address plus 8 to the link register
// (RULE_02) without compressed sets, target is full source; misalignment faults at fetch
// (RULE_03) with compressed sets, mode takes source bit 0 and target bit 0 clears
// (RULE_04) both config fields zero selects raw source; otherwise cleared bit 0 and mode
// (RULE_05) delay slot instruction executes before control reaches the target
// (RULE_06) barrier resolves earlier hazards before the target is fetched and decoded
// (RULE_07) barrier jump is accepted in every operating mode, no privilege check
// (RULE_08) instruction bit 10 selects the hazard barrier variant
// (RULE_09) only hazards from instructions before the jump are cleared, not the slot
// (RULE_10) current generation raises reserved instruction for a transfer op in a slot
// (RULE_11) software must not use equal source and link register fields
// (RULE_12) compressed core: target bit0 zero and bit1 one faults at fetch
// (RULE_13) plain barrier jump decodes as link form with link index zero
// (RULE_14) software clears instruction hazards before running rewritten code
// (RULE_15) mode exchange jump links to register 31 with bit 0 as mode
// (RULE_16) exchange target: slot address upper bits, index shifted left by 2
// (RULE_17) exchange jump inverts the instruction set mode at the transfer
// (RULE_18) exchange opcode 011101 raises reserved instruction with no compressed set
// (RULE_19) current generation does not decode the mode exchange jump
// (RULE_20) link and target are as wide as the general registers
`timescale 1ns/1ps
module rjb_top #(
   parameter int XLEN_P = rjb_pkg::XLEN
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   input  wire logic [rjb_pkg::AVS_ADDR_W-1:0] avs_address_in,
   input  wire logic                          avs_read_in,
   input  wire logic                          avs_write_in,
   input  wire logic [31:0]                   avs_writedata_in,
   input  wire logic [3:0]                    avs_byteenable_in,
   output logic      [31:0]                   avs_readdata_out,
   output logic                               avs_waitrequest_out,
   input  wire logic                          instr_valid_in,
   input  wire logic [rjb_pkg::INSTR_W-1:0]   instr_in,
   input  wire logic [XLEN_P-1:0]             pc_in,
   input  wire logic [XLEN_P-1:0]             src_val_in,
   input  wire logic                          slot_is_cti_in,
   input  wire logic                          hazard_busy_in,
   output logic                               issue_ready_out,
   output logic [rjb_pkg::REG_IDX_W-1:0]      src_idx_out,
   output logic                               link_we_out,
   output logic [rjb_pkg::REG_IDX_W-1:0]      link_idx_out,
   output logic [XLEN_P-1:0]                  link_val_out,
   output logic                               redirect_out,
   output logic [XLEN_P-1:0]                  target_out,
   output logic                               isa_mode_out,
   output logic                               fetch_addr_err_out,
   output logic                               resv_instr_exc_out,
   output logic                               hazard_clear_out,
   output logic                               barrier_done_out
);
   import rjb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // decoder
   rjb_dec_if dec ();
   assign dec.instr = instr_in;
   rjb_decode u_decode (
      .d (dec.dec)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register bus slave: one wait cycle, read data registered
   logic [CTRL_W-1:0] ctrl_q;
   logic              ack_q;
   logic [31:0]       rdata_q;
   logic              mode_q;
   logic [XLEN_P-1:0] tgt_q;
   rjb_state_e        state_q;
   logic              barrier_q;

   wire               bus_req   = avs_read_in | avs_write_in;
   wire               wr_fire   = avs_write_in & ack_q;
   wire               rd_load   = avs_read_in & ~ack_q;
   wire               ctrl_wr   = wr_fire & (avs_address_in == REG_CTRL) & avs_byteenable_in[0];
   wire               code_ca   = ctrl_q[CTRL_CA_BIT];
   wire [ISA_CFG_W-1:0] isa_cfg = ctrl_q[CTRL_ISA_LSB +: ISA_CFG_W];
   wire               gen_r6    = ctrl_q[CTRL_R6_BIT];
   wire               compressed = (isa_cfg != '0) | code_ca; // RULE_04
   wire [31:0]        stat_word = {29'h0, barrier_q, (state_q != RJB_IDLE), mode_q};
   wire [31:0]        rd_mux    = (avs_address_in == REG_CTRL)   ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
                                  (avs_address_in == REG_STATUS) ? stat_word :
                                  (avs_address_in == REG_TGT_LO) ? tgt_q[31:0] :
                                  (avs_address_in == REG_TGT_HI) ? tgt_q[XLEN_P-1:32] : 32'h0;

   assign avs_waitrequest_out = bus_req & ~ack_q;
   assign avs_readdata_out    = rdata_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
         ctrl_q  <= CTRL_RESET;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (rd_load) begin
            rdata_q <= rd_mux;
         end
         if (ctrl_wr) begin
            ctrl_q <= avs_writedata_in[CTRL_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // jump acceptance and target computation
   // no privilege input exists: the barrier jump is legal in every mode  RULE_07
   // equal source and link fields are left to software  RULE_11
   // rewritten code is only safe after software issues a barrier  RULE_14
   wire               xchg_legal = dec.is_xchg & ~gen_r6; // RULE_19
   wire               xchg_ri    = xchg_legal & ~compressed; // RULE_18
   wire               jump_kind  = dec.is_reg_jump | (xchg_legal & compressed);
   wire               take       = instr_valid_in & (state_q == RJB_IDLE) & jump_kind;
   wire               take_ri    = instr_valid_in & (state_q == RJB_IDLE) & xchg_ri;
   wire               slot_cti   = slot_is_cti_in | dec.is_reg_jump | xchg_legal;
   wire               slot_seen  = instr_valid_in & (state_q == RJB_SLOT);
   wire               slot_abort = slot_seen & gen_r6 & slot_cti; // RULE_10
   wire               go_fire    = (state_q == RJB_GO) & ~(barrier_q & hazard_busy_in); // RULE_06

   // full register width link and target paths  RULE_20
   wire [XLEN_P-1:0]  link_sum   = pc_in + XLEN_P'(LINK_OFS); // RULE_01
   wire [XLEN_P-1:0]  slot_pc    = pc_in + XLEN_P'(SLOT_OFS);
   wire [XLEN_P-1:0]  reg_tgt    = compressed ? {src_val_in[XLEN_P-1:1], 1'b0} : src_val_in; // RULE_03
   wire               reg_mode   = compressed ? src_val_in[0] : mode_q; // RULE_04
   wire [XLEN_P-1:0]  xchg_tgt   = {slot_pc[XLEN_P-1:REGION_LSB], dec.index, {ALIGN_SHIFT{1'b0}}}; // RULE_16
   wire [XLEN_P-1:0]  new_tgt    = dec.is_xchg ? xchg_tgt : reg_tgt;
   wire               new_mode   = dec.is_xchg ? ~mode_q : reg_mode; // RULE_17
   wire [XLEN_P-1:0]  new_link   = dec.is_xchg ? {link_sum[XLEN_P-1:1], mode_q} : link_sum; // RULE_15
   // misaligned targets are reported with the target fetch, not at the jump
   wire               fault_unc  = (new_tgt[1:0] != 2'h0); // RULE_02
   wire               fault_cmp  = ~new_mode & new_tgt[1]; // RULE_12
   wire               new_fault  = compressed ? fault_cmp : fault_unc;

   logic              mode_n_q;
   logic              fault_q;
   logic              xchg_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tgt_q     <= '0;
         mode_n_q  <= 1'b0;
         fault_q   <= 1'b0;
         barrier_q <= 1'b0;
         xchg_q    <= 1'b0;
      end else if (take) begin
         tgt_q     <= new_tgt;
         mode_n_q  <= new_mode;
         fault_q   <= new_fault;
         barrier_q <= dec.is_reg_jump & dec.barrier; // RULE_08
         xchg_q    <= dec.is_xchg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing: jump, delay slot, transfer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= RJB_IDLE;
      end else begin
         case (state_q)
            RJB_IDLE: begin
               if (take) begin
                  state_q <= RJB_SLOT;
               end
            end
            RJB_SLOT: begin
               // the slot instruction must pass before the transfer  RULE_05
               if (slot_abort) begin
                  state_q <= RJB_IDLE;
               end else if (slot_seen) begin
                  state_q <= RJB_GO;
               end
            end
            RJB_GO: begin
               if (go_fire) begin
                  state_q <= RJB_IDLE;
               end
            end
            default: begin
               state_q <= RJB_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs; issue ready and source index are combinational
   logic                 link_we_q;
   logic [REG_IDX_W-1:0] link_idx_q;
   logic [XLEN_P-1:0]    link_val_q;
   logic                 redirect_q;
   logic                 ae_q;
   logic                 ri_q;
   logic                 hz_clear_q;
   logic                 bar_done_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         link_we_q  <= 1'b0;
         link_idx_q <= ZERO_REG;
         link_val_q <= '0;
         redirect_q <= 1'b0;
         ae_q       <= 1'b0;
         ri_q       <= 1'b0;
         hz_clear_q <= 1'b0;
         bar_done_q <= 1'b0;
         mode_q     <= 1'b0;
      end else begin
         link_we_q  <= take & (dec.link_idx != ZERO_REG); // RULE_13
         if (take) begin
            link_idx_q <= dec.link_idx;
            link_val_q <= new_link; // RULE_01
         end
         // hazard snapshot taken at the jump, so slot-made hazards stay  RULE_09
         hz_clear_q <= take & dec.is_reg_jump & dec.barrier;
         redirect_q <= go_fire;
         ae_q       <= go_fire & fault_q;
         bar_done_q <= go_fire & barrier_q; // RULE_06
         ri_q       <= take_ri | slot_abort; // RULE_10
         if (go_fire) begin
            mode_q <= mode_n_q; // RULE_17
         end
      end
   end

   assign issue_ready_out    = (state_q != RJB_GO);
   assign src_idx_out        = dec.src_idx;
   assign link_we_out        = link_we_q;
   assign link_idx_out       = link_idx_q;
   assign link_val_out       = link_val_q;
   assign redirect_out       = redirect_q;
   assign target_out         = tgt_q;
   assign isa_mode_out       = mode_q;
   assign fetch_addr_err_out = ae_q;
   assign resv_instr_exc_out = ri_q;
   assign hazard_clear_out   = hz_clear_q;
   assign barrier_done_out   = bar_done_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_link_value: assert property (take && dec.is_reg_jump |=> link_val_q == $past(pc_in) + XLEN_P'(LINK_OFS)) // RULE_01
      else $error("link value is not address plus 8");

   chk_plain_target: assert property (take && dec.is_reg_jump && !compressed |=> tgt_q == $past(src_val_in)) // RULE_04
      else $error("plain target differs from source");

   chk_bit0_cleared: assert property (take && dec.is_reg_jump && compressed
                                     |=> tgt_q[0] == 1'b0 && mode_n_q == $past(src_val_in[0])) // RULE_03
      else $error("compressed target bit 0 or mode wrong");

   chk_slot_before: assert property (take |=> !redirect_q ##1 !redirect_q) // RULE_05
      else $error("transfer before delay slot");

   chk_barrier_wait: assert property (state_q == RJB_GO && barrier_q && hazard_busy_in |=> !redirect_q) // RULE_06
      else $error("redirect while hazards pending");

   chk_hint_bit: assert property (take && dec.is_reg_jump |=> barrier_q == $past(instr_in[HB_BIT])) // RULE_08
      else $error("barrier flag not from bit 10");

   chk_slot_cti: assert property (slot_abort |=> ri_q && state_q == RJB_IDLE ##1 !redirect_q) // RULE_10
      else $error("transfer op in slot not refused");

   chk_xchg_link: assert property (take && dec.is_xchg |=> link_idx_q == LINK_REG_31 && link_val_q[0] == $past(mode_q)) // RULE_15
      else $error("exchange link wrong");

   chk_xchg_toggle: assert property (go_fire && xchg_q |=> redirect_q && mode_q != $past(mode_q)) // RULE_17
      else $error("exchange did not invert mode");

   chk_fetch_fault: assert property (take && dec.is_reg_jump && compressed && !src_val_in[0] && src_val_in[1]
                                    |-> ##[1:300] ((redirect_q && ae_q) || ri_q)) // RULE_12
      else $error("missing address error on fetch");

   chk_link_pulse: assert property (link_we_q |=> !link_we_q) // RULE_01
      else $error("link write too long");

   chk_link_hold: assert property (!take |=> $stable(link_val_q)) // RULE_01
      else $error("link value moved");

   chk_plain_nolink: assert property (take && dec.link_idx == ZERO_REG |=> !link_we_q) // RULE_13
      else $error("link written to zero");

   chk_plain_decode: assert property (instr_valid_in && state_q == RJB_IDLE && dec.is_reg_jump |-> take) // RULE_13
      else $error("register jump not taken");

   chk_any_mode: assert property (instr_valid_in && dec.is_reg_jump && dec.barrier && state_q == RJB_IDLE // RULE_07
      |=> state_q == RJB_SLOT)
      else $error("barrier jump refused");

   chk_clear_at_take: assert property (take && dec.is_reg_jump && dec.barrier |=> hz_clear_q) // RULE_09
      else $error("no hazard clear");

   chk_clear_source: assert property (hz_clear_q |-> $past(take)) // RULE_09
      else $error("stray hazard clear");

   chk_no_jump_fault: assert property (take |=> !ae_q) // RULE_02
      else $error("fault at the jump");

   chk_fault_fetch: assert property (ae_q |-> redirect_q) // RULE_02
      else $error("fault away from fetch");

   chk_unc_align: assert property (take && dec.is_reg_jump && !compressed && src_val_in[1:0] != 2'h0 // RULE_02
      |=> fault_q)
      else $error("misalignment not flagged");

   chk_cmp_fault: assert property (take && dec.is_reg_jump && compressed && !src_val_in[0] && src_val_in[1] // RULE_12
      |=> fault_q)
      else $error("compressed fault missing");

   chk_cmp_nofault: assert property (take && dec.is_reg_jump && compressed && src_val_in[0] |=> !fault_q) // RULE_12
      else $error("false compressed fault");

   chk_mode_stable: assert property (!go_fire |=> $stable(mode_q)) // RULE_17
      else $error("mode moved off transfer");

   chk_xchg_mode: assert property (take && dec.is_xchg |=> mode_n_q != $past(mode_q)) // RULE_17
      else $error("exchange mode not inverted");

   chk_plain_mode: assert property (take && dec.is_reg_jump && !compressed |=> mode_n_q == $past(mode_q)) // RULE_04
      else $error("plain jump moved mode");

   chk_xchg_index: assert property (take && dec.is_xchg // RULE_16
      |=> tgt_q[REGION_LSB-1:0] == {$past(dec.index), 2'b00})
      else $error("exchange low target wrong");

   chk_xchg_refused: assert property (instr_valid_in && xchg_ri && state_q == RJB_IDLE // RULE_18
      |=> ri_q && state_q == RJB_IDLE)
      else $error("exchange not refused");

   chk_r6_no_xchg: assert property (dec.is_xchg && gen_r6 |-> !take) // RULE_19
      else $error("exchange decoded");

   chk_slot_wait: assert property (state_q == RJB_SLOT && !instr_valid_in |=> state_q == RJB_SLOT) // RULE_05
      else $error("slot skipped");

   chk_tgt_hold: assert property (!take |=> $stable(tgt_q)) // RULE_05
      else $error("target moved");

   chk_done_fetch: assert property (bar_done_q |-> redirect_q) // RULE_06
      else $error("barrier done off fetch");

   chk_pre_slot: assert property (slot_seen && !gen_r6 |=> state_q == RJB_GO) // RULE_10
      else $error("older core refused slot");

endmodule : rjb_top

//--- tb/rjb_partner.sv
// register file side model: serves the source register and takes link writes
`timescale 1ns/1ps
module rjb_partner (
   input  wire logic                          clk_in,
   input  wire logic [rjb_pkg::REG_IDX_W-1:0] src_idx_in,
   input  wire logic                          link_we_in,
   input  wire logic [rjb_pkg::REG_IDX_W-1:0] link_idx_in,
   input  wire logic [rjb_pkg::XLEN-1:0]      link_val_in,
   output logic      [rjb_pkg::XLEN-1:0]      src_val_out
);
   import rjb_pkg::*;
   logic [XLEN-1:0] regs [32];

   initial begin
      for (int i = 0; i < 32; i++) begin
         regs[i] = '0;
      end
   end

   // register zero always reads as zero
   assign src_val_out = (src_idx_in == ZERO_REG) ? '0 : regs[src_idx_in];

   always @(posedge clk_in) begin
      if (link_we_in && link_idx_in != ZERO_REG) begin
         regs[link_idx_in] <= link_val_in;
      end
   end
endmodule : rjb_partner

//--- tb/rjb_top_tb.sv
// self-checking bench for the jump control unit
`timescale 1ns/1ps
module rjb_top_tb;
   import rjb_pkg::*;
   typedef struct packed {logic go, ri, lk, hb, er, nm; logic [4:0] li; logic [63:0] lv, tg;} rjb_exp_s;
   logic        clk_in = 0, rst_in = 1, avs_read = 0, avs_write = 0, instr_valid = 0, slot_cti = 0, hazard_busy = 0;
   logic [3:0]  avs_address = '0;
   logic [31:0] avs_writedata = '0, instr = '0, seed = 32'hc20a269a, rdq;
   logic [63:0] pc_r = '0, src_val;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out, issue_ready_out, link_we_out, redirect_out, isa_mode_out;
   logic        fetch_addr_err_out, resv_instr_exc_out, hazard_clear_out, barrier_done_out, md = 0;
   logic [4:0]  src_idx_out, link_idx_out, rs, rd;
   logic [63:0] link_val_out, target_out;
   int          num_errors = 0, n_tests = 0, cyc = 0;

   always #25 clk_in = ~clk_in;

   rjb_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address), .avs_read_in(avs_read),
      .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .instr_valid_in(instr_valid), .instr_in(instr), .pc_in(pc_r), .src_val_in(src_val),
      .slot_is_cti_in(slot_cti), .hazard_busy_in(hazard_busy), .issue_ready_out(issue_ready_out),
      .src_idx_out(src_idx_out), .link_we_out(link_we_out), .link_idx_out(link_idx_out),
      .link_val_out(link_val_out), .redirect_out(redirect_out), .target_out(target_out),
      .isa_mode_out(isa_mode_out), .fetch_addr_err_out(fetch_addr_err_out),
      .resv_instr_exc_out(resv_instr_exc_out), .hazard_clear_out(hazard_clear_out),
      .barrier_done_out(barrier_done_out));

   rjb_partner p_u (.clk_in(clk_in), .src_idx_in(src_idx_out), .link_we_in(link_we_out),
      .link_idx_in(link_idx_out), .link_val_in(link_val_out), .src_val_out(src_val));

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] lfsr();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : lfsr

   function automatic logic [31:0] enc_reg(logic [4:0] s, logic [4:0] d, logic hb);
      return {OP_SPECIAL, s, 5'h00, d, hb, 4'h0, FN_REG_JUMP};
   endfunction : enc_reg

   // expected outcome of one jump from configuration, word, address, source and mode
   function automatic rjb_exp_s pred(logic [3:0] cfg, logic [31:0] ins, logic [63:0] pc, logic [63:0] src,
                                      logic control_transfer_op, logic m);
      rjb_exp_s e;
      logic comp, isx, isr;
      logic [63:0] sa;
      comp = cfg[0] | (cfg[2:1] != 2'h0);
      isx = (ins[31:26] == OP_MODE_XCHG) && !cfg[3];
      isr = (ins[31:26] == OP_SPECIAL) && (ins[5:0] == FN_REG_JUMP) && (ins[20:16] == 5'h00);
      e.hb = isr & ins[HB_BIT];
      e.ri = (isx & !comp) | (isr & cfg[3] & control_transfer_op);
      e.go = ((isx & comp) | isr) & !e.ri;
      e.li = isx ? LINK_REG_31 : ins[15:11];
      e.lk = ((isx & comp) | isr) && e.li != ZERO_REG;
      e.lv = pc + LINK_OFS;
      if (isx) e.lv[0] = m;
      sa = pc + SLOT_OFS;
      e.tg = isx ? {sa[63:28], ins[25:0], 2'b00} : (comp ? {src[63:1], 1'b0} : src);
      e.er = isr & (comp ? (!src[0] & src[1]) : (src[1:0] != 2'b00));
      e.nm = isx ? !m : (comp ? src[0] : m);
      return e;
   endfunction : pred

   task automatic av_acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av_acc

   task automatic run(input logic [3:0] cfg, input logic [31:0] ins, input logic [63:0] pc,
                      input logic [63:0] src, input logic control_transfer_op, input logic bsy);
      rjb_exp_s e;
      int gl, gh, gx, gr, kr;
      e = pred(cfg, ins, pc, src, control_transfer_op, md);
      av_acc(1'b1, REG_CTRL, {28'h0, cfg}, rdq);
      p_u.regs[ins[25:21]] = src;
      gl = 0; gh = 0; gx = 0; gr = 0; kr = -1;
      @(posedge clk_in);
      instr_valid <= 1'b1;
      instr <= ins;
      pc_r <= pc;
      hazard_busy <= bsy;
      @(posedge clk_in);
      instr <= 32'h0;
      pc_r <= pc + SLOT_OFS;
      slot_cti <= control_transfer_op;
      for (int k = 0; k < 10; k++) begin
         @(negedge clk_in);
         if (link_we_out === 1'b1) begin
            gl++;
            chk(64'(link_idx_out), 64'(e.li));
            chk(link_val_out, e.lv);
         end
         if (hazard_clear_out === 1'b1) gh++;
         if (resv_instr_exc_out === 1'b1) gx++;
         if (k == 1) chk(64'(issue_ready_out), 64'(!e.go));
         if (redirect_out === 1'b1) begin
            gr++;
            kr = k;
            chk(target_out, e.tg);
            chk(64'(isa_mode_out), 64'(e.nm));
            chk(64'(fetch_addr_err_out), 64'(e.er));
            chk(64'(barrier_done_out), 64'(e.hb));
         end
         @(posedge clk_in);
         if (k == 0) begin
            instr_valid <= 1'b0;
            slot_cti <= 1'b0;
         end
         if (k == 4) hazard_busy <= 1'b0;
      end
      chk(64'(gl), 64'(e.lk));
      chk(64'(gh), 64'(e.hb));
      chk(64'(gx), 64'(e.ri));
      chk(64'(gr), 64'(e.go));
      if (e.go) begin
         chk(64'(kr), (e.hb & bsy) ? 64'h6 : 64'h2);
         md = e.nm;
         av_acc(1'b0, REG_TGT_LO, 32'h0, rdq);
         chk({32'h0, rdq}, {32'h0, e.tg[31:0]});
         av_acc(1'b0, REG_TGT_HI, 32'h0, rdq);
         chk({32'h0, rdq}, e.tg[63:32]);
         av_acc(1'b0, REG_STATUS, 32'h0, rdq);
         chk(64'(rdq[STAT_MODE_BIT]), 64'(md));
      end
   endtask : run

   initial begin
      logic [31:0] r, r2;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      av_acc(1'b0, REG_CTRL, 32'h0, rdq);
      chk({32'h0, rdq}, 64'h0);
      av_acc(1'b0, REG_STATUS, 32'h0, rdq);
      chk({32'h0, rdq}, 64'h0);
      av_acc(1'b1, REG_CTRL, 32'h5, rdq);
      av_acc(1'b0, REG_CTRL, 32'h0, rdq);
      chk({32'h0, rdq}, 64'h5);
      av_acc(1'b1, 4'h6, 32'hffff_ffff, rdq);
      av_acc(1'b0, 4'h6, 32'h0, rdq);
      chk({32'h0, rdq}, 64'h0);
      run(4'h0, enc_reg(5'h03, 5'h1f, 1'b1), 64'h100, 64'h0000_0040_0000_1002, 1'b0, 1'b1);
      run(4'h2, enc_reg(5'h04, 5'h00, 1'b0), 64'h200, 64'h3001, 1'b0, 1'b0);
      run(4'h2, enc_reg(5'h05, 5'h06, 1'b1), 64'h300, 64'h4002, 1'b0, 1'b1);
      run(4'h1, {OP_MODE_XCHG, 26'h2aa_aaaa}, 64'h1fff_fffc, 64'h0, 1'b0, 1'b0);
      run(4'h0, {OP_MODE_XCHG, 26'h000_0123}, 64'h400, 64'h0, 1'b0, 1'b0);
      run(4'ha, {OP_MODE_XCHG, 26'h000_0123}, 64'h500, 64'h0, 1'b0, 1'b0);
      run(4'h8, enc_reg(5'h07, 5'h08, 1'b1), 64'h600, 64'h700, 1'b1, 1'b0);
      for (int i = 0; i < 40; i++) begin
         r = lfsr();
         r2 = lfsr();
         rs = 5'(r % 31 + 1);
         rd = (r[9:5] == rs) ? rs + 5'h01 : r[9:5];
         run(r[15:12], (r[10] & r[18]) ? {OP_MODE_XCHG, r2[25:0]} : enc_reg(rs, rd, r[11]),
             {lfsr(), lfsr() & 32'hffff_fffc}, {lfsr(), r2}, r[16], r[17]);
      end
      test_done();
   end
endmodule : rjb_top_tb
